// ==== sest_pkg.sv ====
// Purpose: Shared constants and command codes for the status event summary tree
// Assumes: One system clock; host command port on the same clock
// Notes:   Bit positions and reset values are named here and nowhere else
package sest_pkg;

	localparam int DW  = 16;
	localparam int NCH = 2;

	localparam logic [DW-1:0] ZERO_WORD = 16'h0000;

	// Per-output event bits
	localparam int OUTPUT_REGULATION_SUMMARY_VOLT_BIT = 0;
	localparam int OUTPUT_REGULATION_SUMMARY_CURR_BIT = 1;

	// Per-output condition bits
	localparam int COND_CC_BIT = 0;
	localparam int COND_CV_BIT = 1;
	localparam int COND_CP_BIT = 2;

	// Instrument register: output n reports at bit n
	localparam int INST_CH_BASE = 1;

	// Questionable register output-summary flag
	localparam int QUESTIONABLE_STATUS_EVENTS_OUTPUT_REGULATION_SUMMARY_BIT = 13;

	// Output index values on the command port
	localparam logic [1:0] IDX_FIRST  = 2'h1;
	localparam logic [1:0] IDX_SECOND = 2'h2;

	typedef enum logic [3:0] {
		OP_NOP       = 4'h0,
		OP_RD_QEVT   = 4'h1,
		OP_RD_QEN    = 4'h2,
		OP_WR_QEN    = 4'h3,
		OP_RD_IEVT   = 4'h4,
		OP_RD_IEN    = 4'h5,
		OP_WR_IEN    = 4'h6,
		OP_RD_SEVT   = 4'h7,
		OP_RD_SEN    = 4'h8,
		OP_WR_SEN    = 4'h9,
		OP_RD_COND   = 4'ha,
		OP_CLS       = 4'hb,
		OP_INST_RST  = 4'hc,
		OP_DEV_CLEAR = 4'hd
	} sest_op_t;

endpackage

// ==== sest_tree.sv ====
// Purpose: Latched status event tree for a two-output instrument
// Assumes: Mode pins are asynchronous; command port is synchronous to MCLK
// Notes:   One command per cycle at most; every command gets one answer
`timescale 1ns/100ps

module sest_tree
	import sest_pkg::*;
(
	input  wire logic          MCLK,
	input  wire logic          RST_B,
	input  wire logic          CMD_VALID,
	input  wire logic [3:0]    CMD_OP,
	input  wire logic [1:0]    CMD_INDEX,
	input  wire logic [DW-1:0] CMD_WDATA,
	input  wire logic [NCH-1:0] OUT_ON,
	input  wire logic [NCH-1:0] VOLT_MODE,
	input  wire logic [NCH-1:0] CURR_MODE,
	input  wire logic [NCH-1:0] POWER_MODE,
	output logic               RSP_VALID,
	output logic [DW-1:0]      RSP_DATA,
	output logic               RSP_ERR,
	output logic               QUESTIONABLE_STATUS_EVENTS_SUMMARY
);

	// OR of enabled event bits
	function automatic logic summ(input logic [DW-1:0] ev, input logic [DW-1:0] en);
		summ = |(ev & en);
	endfunction

	// Index 1 or 2 selects an output
	function automatic logic idx_ok(input logic [1:0] idx);
		idx_ok = (idx == IDX_FIRST) || (idx == IDX_SECOND);
	endfunction

	function automatic logic idx_is(input logic [1:0] idx, input int ch);
		idx_is = (ch == 0) ? (idx == IDX_FIRST) : (idx == IDX_SECOND);
	endfunction

	// Live mode word for one output
	function automatic logic [DW-1:0] cond_word(input logic on, input logic cv,
		input logic cc, input logic cp);
		logic [DW-1:0] w;
		w = ZERO_WORD;
		if (on) begin
			if (cv) begin
				w[COND_CV_BIT] = 1'b1;
			end else if (cp) begin
				w[COND_CP_BIT] = 1'b1;
			end else if (cc) begin
				w[COND_CC_BIT] = 1'b1;
			end else begin
				w[COND_CV_BIT] = 1'b1;
				w[COND_CP_BIT] = 1'b1;
			end
		end
		cond_word = w;
	endfunction

	// Reset release
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Mode pin synchronisers
	logic [4*NCH-1:0] pin_meta_q;
	logic [4*NCH-1:0] pin_q;

	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_meta_q <= '0;
			pin_q      <= '0;
		end else begin
			pin_meta_q <= {POWER_MODE, CURR_MODE, VOLT_MODE, OUT_ON};
			pin_q      <= pin_meta_q;
		end
	end

	logic [NCH-1:0] on_s;
	logic [NCH-1:0] cv_s;
	logic [NCH-1:0] cc_s;
	logic [NCH-1:0] cp_s;

	assign on_s = pin_q[NCH-1:0];
	assign cv_s = pin_q[2*NCH-1:NCH];
	assign cc_s = pin_q[3*NCH-1:2*NCH];
	assign cp_s = pin_q[4*NCH-1:3*NCH];

	// Command decode
	sest_op_t op;
	logic     cls;
	logic     rd_qevt;
	logic     rd_ievt;
	logic     wr_qen;
	logic     wr_ien;

	assign op      = sest_op_t'(CMD_OP);
	assign cls     = CMD_VALID && (op == OP_CLS);
	assign rd_qevt = CMD_VALID && (op == OP_RD_QEVT);
	assign rd_ievt = CMD_VALID && (op == OP_RD_IEVT);
	assign wr_qen  = CMD_VALID && (op == OP_WR_QEN);
	assign wr_ien  = CMD_VALID && (op == OP_WR_IEN);

	// Per-output registers
	logic [DW-1:0]  sev_q [NCH];
	logic [DW-1:0]  sen_q [NCH];
	logic [DW-1:0]  cond  [NCH];
	logic [NCH-1:0] was_cv_q;
	logic [NCH-1:0] was_cc_q;
	logic [NCH-1:0] ch_sum;

	for (genvar c = 0; c < NCH; c++) begin : g_out
		logic          rd_sev;
		logic          wr_sen;
		logic [DW-1:0] set_v;
		logic [DW-1:0] sev_d;

		assign rd_sev = CMD_VALID && (op == OP_RD_SEVT) && idx_is(CMD_INDEX, c);
		assign wr_sen = CMD_VALID && (op == OP_WR_SEN) && idx_is(CMD_INDEX, c);
		assign cond[c] = cond_word(on_s[c], cv_s[c], cc_s[c], cp_s[c]);

		always_comb begin
			set_v = ZERO_WORD;
			set_v[OUTPUT_REGULATION_SUMMARY_VOLT_BIT] = was_cv_q[c] && on_s[c] && !cv_s[c];
			set_v[OUTPUT_REGULATION_SUMMARY_CURR_BIT] = was_cc_q[c] && on_s[c] && !cc_s[c];
			// Set wins over clear in the same cycle
			sev_d = ((rd_sev || cls) ? ZERO_WORD : sev_q[c]) | set_v;
		end

		always_ff @(posedge MCLK or negedge rst_n_q) begin
			if (!rst_n_q) begin
				was_cv_q[c] <= 1'b0;
				was_cc_q[c] <= 1'b0;
			end else begin
				was_cv_q[c] <= on_s[c] && cv_s[c];
				was_cc_q[c] <= on_s[c] && cc_s[c];
			end
		end

		always_ff @(posedge MCLK or negedge rst_n_q) begin
			if (!rst_n_q) begin
				sev_q[c] <= ZERO_WORD;
			end else begin
				sev_q[c] <= sev_d;
			end
		end

		always_ff @(posedge MCLK or negedge rst_n_q) begin
			if (!rst_n_q) begin
				sen_q[c] <= ZERO_WORD;
			end else if (wr_sen) begin
				sen_q[c] <= CMD_WDATA;
			end
		end

		assign ch_sum[c] = summ(sev_q[c], sen_q[c]);
	end

	// Instrument register
	logic [DW-1:0] iev_q;
	logic [DW-1:0] ien_q;
	logic [DW-1:0] iset;

	always_comb begin
		iset = ZERO_WORD;
		for (int c = 0; c < NCH; c++) begin
			iset[INST_CH_BASE + c] = ch_sum[c];
		end
	end

	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			iev_q <= ZERO_WORD;
		end else begin
			// Clear-status also drops the level below, so its summary is stale
			iev_q <= cls ? ZERO_WORD : (rd_ievt ? ZERO_WORD : iev_q) | iset;
		end
	end

	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ien_q <= ZERO_WORD;
		end else if (wr_ien) begin
			ien_q <= CMD_WDATA;
		end
	end

	// Questionable register, only the output-summary flag exists
	logic          qflag_q;
	logic [DW-1:0] qev;
	logic [DW-1:0] qen_q;

	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			qflag_q <= 1'b0;
		end else begin
			qflag_q <= cls ? 1'b0 : (rd_qevt ? 1'b0 : qflag_q) | summ(iev_q, ien_q);
		end
	end

	always_comb begin
		qev = ZERO_WORD;
		qev[QUESTIONABLE_STATUS_EVENTS_OUTPUT_REGULATION_SUMMARY_BIT] = qflag_q;
	end

	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			qen_q <= ZERO_WORD;
		end else if (wr_qen) begin
			qen_q <= CMD_WDATA;
		end
	end

	// Status byte summary bit
	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			QUESTIONABLE_STATUS_EVENTS_SUMMARY <= 1'b0;
		end else begin
			QUESTIONABLE_STATUS_EVENTS_SUMMARY <= summ(qev, qen_q);
		end
	end

	// Answer path
	logic [DW-1:0] rsp_d;
	logic          err_d;
	logic          sel;

	assign sel = (CMD_INDEX == IDX_SECOND);

	always_comb begin
		rsp_d = ZERO_WORD;
		err_d = 1'b0;
		case (op)
			OP_RD_QEVT:   rsp_d = qev;
			OP_RD_QEN:    rsp_d = qen_q;
			OP_WR_QEN:    rsp_d = ZERO_WORD;
			OP_RD_IEVT:   rsp_d = iev_q;
			OP_RD_IEN:    rsp_d = ien_q;
			OP_WR_IEN:    rsp_d = ZERO_WORD;
			OP_RD_SEVT:   begin
				err_d = !idx_ok(CMD_INDEX);
				rsp_d = err_d ? ZERO_WORD : sev_q[sel];
			end
			OP_RD_SEN:    begin
				err_d = !idx_ok(CMD_INDEX);
				rsp_d = err_d ? ZERO_WORD : sen_q[sel];
			end
			OP_WR_SEN:    err_d = !idx_ok(CMD_INDEX);
			OP_RD_COND:   begin
				err_d = !idx_ok(CMD_INDEX);
				rsp_d = err_d ? ZERO_WORD : cond[sel];
			end
			OP_CLS:       rsp_d = ZERO_WORD;
			OP_INST_RST:  rsp_d = ZERO_WORD;
			OP_DEV_CLEAR: rsp_d = ZERO_WORD;
			OP_NOP:       rsp_d = ZERO_WORD;
			default:      err_d = 1'b1;
		endcase
	end

	always_ff @(posedge MCLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			RSP_VALID <= 1'b0;
			RSP_DATA  <= ZERO_WORD;
			RSP_ERR   <= 1'b0;
		end else begin
			RSP_VALID <= CMD_VALID;
			RSP_DATA  <= CMD_VALID ? rsp_d : ZERO_WORD;
			RSP_ERR   <= CMD_VALID && err_d;
		end
	end

endmodule // sest_tree

// ==== sest_tree_props.sv ====
// Purpose: Port checker for the status event tree
// Assumes: Answer one cycle after a taken command
// Notes:   Bound to every sest_tree instance
`timescale 1ns/100ps
module sest_tree_chk
	import sest_pkg::*;
(
	input wire logic           MCLK,
	input wire logic           RST_B,
	input wire logic           CMD_VALID,
	input wire logic [3:0]     CMD_OP,
	input wire logic [1:0]     CMD_INDEX,
	input wire logic [NCH-1:0] OUT_ON,
	input wire logic [NCH-1:0] VOLT_MODE,
	input wire logic           RSP_VALID,
	input wire logic [DW-1:0]  RSP_DATA,
	input wire logic           RSP_ERR,
	input wire logic           QUESTIONABLE_STATUS_EVENTS_SUMMARY
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	wire rd_c1 = CMD_VALID && CMD_OP == OP_RD_COND && CMD_INDEX == IDX_FIRST;
	wire rd_s  = CMD_VALID && CMD_OP == OP_RD_SEVT;
	property p_answer; RSP_VALID == $past(CMD_VALID); endproperty
	a_answer: assert property (p_answer) else $error("answer timing wrong");
	property p_quiet; !RSP_VALID |-> RSP_DATA == ZERO_WORD && !RSP_ERR; endproperty
	a_quiet: assert property (p_quiet) else $error("data without answer");
	property p_questionable_status_events;
		RSP_VALID && $past(CMD_OP) == OP_RD_QEVT |-> (RSP_DATA & 16'hdfff) == ZERO_WORD;
	endproperty
	a_questionable_status_events: assert property (p_questionable_status_events) else $error("unused bit set");
	property p_badop; CMD_VALID && CMD_OP > 4'hd |=> RSP_ERR; endproperty
	a_badop: assert property (p_badop) else $error("bad opcode accepted");
	property p_badidx; rd_s && CMD_INDEX == 2'h3 |=> RSP_ERR && RSP_DATA == ZERO_WORD; endproperty
	a_badidx: assert property (p_badidx) else $error("bad index accepted");
	property p_goodidx; rd_s && CMD_INDEX == IDX_SECOND |=> !RSP_ERR; endproperty
	a_goodidx: assert property (p_goodidx) else $error("good index refused");
	property p_off; !OUT_ON[0] [*4] ##0 rd_c1 |=> RSP_DATA == ZERO_WORD; endproperty
	a_off: assert property (p_off) else $error("off output not zero");
	property p_cv; (OUT_ON[0] && VOLT_MODE[0]) [*4] ##0 rd_c1 |=> RSP_DATA == 16'h0002; endproperty
	a_cv: assert property (p_cv) else $error("voltage mode not bit 1");
	c_questionable_status_events: cover property ($rose(QUESTIONABLE_STATUS_EVENTS_SUMMARY));
	c_err: cover property (RSP_ERR);
	c_cv: cover property ((OUT_ON[0] && VOLT_MODE[0]) [*4] ##0 rd_c1);
endmodule // sest_tree_chk

bind sest_tree sest_tree_chk i_chk (.MCLK, .RST_B, .CMD_VALID, .CMD_OP, .CMD_INDEX, .OUT_ON,
	.VOLT_MODE, .RSP_VALID, .RSP_DATA, .RSP_ERR, .QUESTIONABLE_STATUS_EVENTS_SUMMARY);

// ==== sest_host.sv ====
// Purpose: Host model issuing status commands
// Assumes: Answer read 1 ns after the taking edge
// Notes:   Lines change 1 ns after the rising edge
`timescale 1ns/100ps
module sest_host
	import sest_pkg::*;
(
	input  wire logic          MCLK,
	output logic               CMD_VALID,
	output logic [3:0]         CMD_OP,
	output logic [1:0]         CMD_INDEX,
	output logic [DW-1:0]      CMD_WDATA,
	input  wire logic          RSP_VALID,
	input  wire logic [DW-1:0] RSP_DATA,
	input  wire logic          RSP_ERR
);
	initial begin
		CMD_VALID = 1'b0;
		CMD_OP = 4'h0;
		CMD_INDEX = 2'h0;
		CMD_WDATA = 16'h0000;
	end
	task automatic cmd(input logic [3:0] op, input logic [1:0] idx, input logic [DW-1:0] wd,
		output logic [DW-1:0] rd, output logic err);
		@(posedge MCLK);
		#1;
		CMD_VALID = 1'b1;
		CMD_OP = op;
		CMD_INDEX = idx;
		CMD_WDATA = wd;
		@(posedge MCLK);
		#1;
		CMD_VALID = 1'b0;
		CMD_OP = ~op;
		CMD_INDEX = ~idx;
		CMD_WDATA = ~wd;
		rd = (RSP_VALID === 1'b1) ? RSP_DATA : 'x;
		err = RSP_ERR;
	endtask
endmodule // sest_host

// ==== testbench.sv ====
// Purpose: Self-checking bench for the status event tree
// Assumes: Mode pins driven 1 ns after the edge
// Notes:   One task per scenario
`timescale 1ns/100ps
module testbench;
	import sest_pkg::*;
	logic           MCLK = 1'b0;
	logic           RST_B = 1'b0;
	logic [NCH-1:0] out_on, volt, curr, pwr;
	logic           cmd_valid, rsp_valid, rsp_err, questionable_status_events_sum, err;
	logic [3:0]     cmd_op;
	logic [1:0]     cmd_index;
	logic [DW-1:0]  cmd_wdata, rsp_data, rd;
	int             n_fail = 0;
	int             cmp_count = 0;
	always #12.5 MCLK = ~MCLK;
	sest_tree i_dut (.MCLK(MCLK), .RST_B(RST_B), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
		.CMD_INDEX(cmd_index), .CMD_WDATA(cmd_wdata), .OUT_ON(out_on), .VOLT_MODE(volt),
		.CURR_MODE(curr), .POWER_MODE(pwr), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
		.RSP_ERR(rsp_err), .QUESTIONABLE_STATUS_EVENTS_SUMMARY(questionable_status_events_sum));
	sest_host i_host (.MCLK(MCLK), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
		.CMD_INDEX(cmd_index), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid),
		.RSP_DATA(rsp_data), .RSP_ERR(rsp_err));
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [DW-1:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task automatic wr(input logic [3:0] op, input logic [1:0] idx, input logic [DW-1:0] v);
		i_host.cmd(op, idx, v, rd, err);
	endtask
	task automatic rc(input logic [3:0] op, input logic [1:0] idx, input logic [DW-1:0] e,
		input string nm);
		i_host.cmd(op, idx, 16'h0000, rd, err);
		chk(nm, rd, e);
	endtask
	task automatic lose(input int ch, input bit v);
		out_on[ch] = 1'b1;
		if (v) volt[ch] = 1'b1; else curr[ch] = 1'b1;
		wt(5);
		if (v) volt[ch] = 1'b0; else curr[ch] = 1'b0;
		wt(8);
		if (v) volt[ch] = 1'b1; else curr[ch] = 1'b1;
		wt(4);
	endtask
	task automatic t_enables;
		wr(OP_WR_SEN, IDX_FIRST, 16'h0003);
		wr(OP_WR_SEN, IDX_SECOND, 16'h0003);
		wr(OP_WR_IEN, 2'h0, 16'h000e);
		wr(OP_WR_QEN, 2'h0, 16'h2000);
		rc(OP_RD_SEN, IDX_SECOND, 16'h0003, "sen2");
		rc(OP_RD_IEN, 2'h0, 16'h000e, "ien");
		rc(OP_RD_QEN, 2'h0, 16'h2000, "qen");
		rc(OP_RD_QEN, 2'h0, 16'h2000, "qen again");
		$display("test enables done");
	endtask
	task automatic t_chain;
		lose(0, 1'b1);
		chk("questionable_status_events_sum", {15'h0000, questionable_status_events_sum}, 16'h0001);
		rc(OP_RD_SEVT, IDX_FIRST, 16'h0001, "sev1");
		rc(OP_RD_SEVT, IDX_FIRST, 16'h0000, "sev1 again");
		rc(OP_RD_IEVT, 2'h0, 16'h0002, "iev");
		rc(OP_RD_QEVT, 2'h0, 16'h2000, "qev");
		rc(OP_RD_QEVT, 2'h0, 16'h0000, "qev again");
		wt(2);
		chk("questionable_status_events_sum low", {15'h0000, questionable_status_events_sum}, 16'h0000);
		$display("test chain done");
	endtask
	task automatic t_keep;
		lose(1, 1'b0);
		wr(OP_INST_RST, 2'h0, 16'h0000);
		wr(OP_DEV_CLEAR, 2'h0, 16'h0000);
		rc(OP_RD_SEVT, IDX_SECOND, 16'h0002, "sev2");
		rc(OP_RD_IEVT, 2'h0, 16'h0004, "iev2");
		lose(1, 1'b0);
		wr(OP_CLS, 2'h0, 16'h0000);
		rc(OP_RD_SEVT, IDX_SECOND, 16'h0000, "sev2 cls");
		rc(OP_RD_IEVT, 2'h0, 16'h0000, "iev cls");
		rc(OP_RD_QEVT, 2'h0, 16'h0000, "qev cls");
		rc(OP_RD_SEN, IDX_FIRST, 16'h0003, "sen1 cls");
		$display("test keep done");
	endtask
	task automatic t_cond;
		logic [DW-1:0] ce [4] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006};
		for (int i = 0; i < 4; i++) begin
			out_on[0] = (i != 0);
			volt[0] = (i == 1);
			pwr[0] = (i == 2);
			wt(4);
			rc(OP_RD_COND, IDX_FIRST, ce[i], "cond");
		end
		$display("test cond done");
	endtask
	task automatic t_refuse;
		i_host.cmd(OP_RD_SEVT, 2'h3, 16'h0000, rd, err);
		chk("bad idx err", {15'h0000, err}, 16'h0001);
		chk("bad idx data", rd, 16'h0000);
		i_host.cmd(4'hf, 2'h0, 16'h0000, rd, err);
		chk("bad op err", {15'h0000, err}, 16'h0001);
		$display("test refuse done");
	endtask
	task automatic t_qen0;
		wr(OP_WR_QEN, 2'h0, 16'h0000);
		rc(OP_RD_QEN, 2'h0, 16'h0000, "qen zero");
		lose(0, 1'b1);
		chk("questionable_status_events_sum masked", {15'h0000, questionable_status_events_sum}, 16'h0000);
		rc(OP_RD_QEVT, 2'h0, 16'h2000, "qev masked");
		$display("test qen0 done");
	endtask
	initial begin
		out_on = 2'h0;
		volt = 2'h0;
		curr = 2'h0;
		pwr = 2'h0;
		wt(5);
		RST_B = 1'b1;
		wt(3);
		t_enables();
		t_chain();
		t_keep();
		t_cond();
		t_refuse();
		t_qen0();
		tally_and_finish();
	end
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule // testbench
